// [inc/asp_pkg.sv]
// Constants, types and decode helpers for the status and power register slice.
package asp_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam logic [5:0] IDX_POSTURE = 6'h0c;
  localparam logic [5:0] IDX_QUEUE   = 6'h0e;
  localparam logic [5:0] IDX_RANGE   = 6'h0f;
  localparam logic [5:0] IDX_CUTOFF  = 6'h10;
  localparam logic [5:0] IDX_POWER   = 6'h11;

  // Reset values and writable-bit masks of the configuration registers.
  localparam logic [7:0] RANGE_RST   = 8'h03;
  localparam logic [7:0] CUTOFF_RST  = 8'h0f;
  localparam logic [7:0] POWER_RST   = 8'h00;
  localparam logic [7:0] RANGE_MASK  = 8'h0f;
  localparam logic [7:0] CUTOFF_MASK = 8'h1f;
  localparam logic [7:0] POWER_MASK  = 8'hfe;

  // Field positions.
  localparam int unsigned POST_FLAT_BIT   = 7;
  localparam int unsigned POST_ORIENT_LSB = 4;
  localparam int unsigned QUEUE_OVF_BIT   = 7;
  localparam int unsigned PWR_MODE_LSB    = 5;
  localparam int unsigned SLEEP_LSB       = 1;

  // Full-scale and power mode codes.
  localparam logic [3:0] RANGE_2G      = 4'h3;
  localparam logic [3:0] RANGE_4G      = 4'h5;
  localparam logic [3:0] RANGE_8G      = 4'h8;
  localparam logic [3:0] RANGE_16G     = 4'hc;
  localparam logic [2:0] PWR_NORMAL_CD = 3'h0;
  localparam logic [2:0] PWR_DEEP_CD   = 3'h1;
  localparam logic [2:0] PWR_LOW_CD    = 3'h2;
  localparam logic [2:0] PWR_SUSP_CD   = 3'h4;

  // Queue capacity in frames.
  localparam logic [6:0] QUEUE_DEPTH = 7'h20;

  // Filter cutoffs in hundredths of a hertz.
  localparam int unsigned CUT_7_81_HZ  = 781;
  localparam int unsigned CUT_15_63_HZ = 1563;
  localparam int unsigned CUT_31_25_HZ = 3125;
  localparam int unsigned CUT_62_5_HZ  = 6250;
  localparam int unsigned CUT_125_HZ   = 12500;
  localparam int unsigned CUT_250_HZ   = 25000;
  localparam int unsigned CUT_500_HZ   = 50000;
  localparam int unsigned CUT_1000_HZ  = 100000;

  // Sleep phase lengths in microseconds.
  localparam int unsigned SLP_0_5_MS = 500;
  localparam int unsigned SLP_1_MS   = 1000;
  localparam int unsigned SLP_2_MS   = 2000;
  localparam int unsigned SLP_4_MS   = 4000;
  localparam int unsigned SLP_6_MS   = 6000;
  localparam int unsigned SLP_10_MS  = 10000;
  localparam int unsigned SLP_25_MS  = 25000;
  localparam int unsigned SLP_50_MS  = 50000;
  localparam int unsigned SLP_100_MS = 100000;
  localparam int unsigned SLP_500_MS = 500000;
  localparam int unsigned SLP_1_S    = 1000000;

  typedef enum logic [1:0] {
    ASP_FS_2G  = 2'b00,
    ASP_FS_4G  = 2'b01,
    ASP_FS_8G  = 2'b10,
    ASP_FS_16G = 2'b11
  } asp_fs_t;

  typedef enum logic [1:0] {
    ASP_PM_NORMAL = 2'b00,
    ASP_PM_DEEP   = 2'b01,
    ASP_PM_LOW    = 2'b10,
    ASP_PM_SUSP   = 2'b11
  } asp_pmode_t;

  typedef enum logic [1:0] {
    ASP_HOLD_NONE = 2'b00,
    ASP_HOLD_TEMP = 2'b01,
    ASP_HOLD_PERM = 2'b10
  } asp_hold_t;

  typedef struct packed {
    logic sign;
    logic z;
    logic y;
    logic x;
  } asp_high_t;

  function automatic logic [16:0] asp_cutoff(input logic [4:0] code);
    logic [16:0] v;
    v = 17'(CUT_1000_HZ);
    if (!code[4] && !code[3])
      v = 17'(CUT_7_81_HZ);
    else if (!code[4])
    begin
      case (code[2:0])
        3'h0:    v = 17'(CUT_7_81_HZ);
        3'h1:    v = 17'(CUT_15_63_HZ);
        3'h2:    v = 17'(CUT_31_25_HZ);
        3'h3:    v = 17'(CUT_62_5_HZ);
        3'h4:    v = 17'(CUT_125_HZ);
        3'h5:    v = 17'(CUT_250_HZ);
        3'h6:    v = 17'(CUT_500_HZ);
        default: v = 17'(CUT_1000_HZ);
      endcase
    end
    return v;
  endfunction : asp_cutoff

  function automatic logic [19:0] asp_sleep(input logic [3:0] code);
    logic [19:0] v;
    case (code)
      4'h6:    v = 20'(SLP_1_MS);
      4'h7:    v = 20'(SLP_2_MS);
      4'h8:    v = 20'(SLP_4_MS);
      4'h9:    v = 20'(SLP_6_MS);
      4'ha:    v = 20'(SLP_10_MS);
      4'hb:    v = 20'(SLP_25_MS);
      4'hc:    v = 20'(SLP_50_MS);
      4'hd:    v = 20'(SLP_100_MS);
      4'he:    v = 20'(SLP_500_MS);
      4'hf:    v = 20'(SLP_1_S);
      default: v = 20'(SLP_0_5_MS);
    endcase
    return v;
  endfunction : asp_sleep

endpackage : asp_pkg

// [core/asp_queue_stat.sv]
// Frame counter and overflow flag of the sample queue.
`timescale 1ns/1ps
module asp_queue_stat
  import asp_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Queue events.
  input  wire logic       frame_push_i,
  input  wire logic       frame_pop_i,
  input  wire logic       setup_wr_i,
  // Status.
  output logic [6:0]      count_o,
  output logic            overflow_o
);

  logic full;
  logic empty;

  assign full  = (count_o == QUEUE_DEPTH);
  assign empty = (count_o == 7'h00);

  // A push into a full queue is dropped, so the count saturates.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      count_o <= 7'h00;
    else if (setup_wr_i)
      count_o <= 7'h00;
    else if (frame_push_i && !full && !(frame_pop_i && !empty))
      count_o <= count_o + 7'h01;
    else if (frame_pop_i && !empty && !frame_push_i)
      count_o <= count_o - 7'h01;
  end

  // An overrun in the clearing cycle keeps the flag set.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      overflow_o <= 1'b0;
    else if (frame_push_i && full && !(frame_pop_i && !empty))
      overflow_o <= 1'b1;
    else if (setup_wr_i)
      overflow_o <= 1'b0;
  end

  chk_ovf_sticky_clear: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    overflow_o && !setup_wr_i |=> overflow_o)
    else $error("overflow flag dropped without a setup write");

  chk_count_bounded: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    count_o <= QUEUE_DEPTH)
    else $error("frame count above queue depth");

  chk_setup_zeroes: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    setup_wr_i |=> count_o == 7'h00)
    else $error("frame count not zero after setup write");

  chk_ovf_on_full: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    frame_push_i && !frame_pop_i && full |=> overflow_o &&
      count_o == ($past(setup_wr_i) ? 7'h00 : QUEUE_DEPTH))
    else $error("push into full queue did not flag overflow");

endmodule : asp_queue_stat

// [core/asp_status_power_regs.sv]
// APB register slice: posture and peak status, queue status, power config.
`timescale 1ns/1ps
// Contract
// - flat bit shows flat position when enabled
// - top posture bit gives z facing
// - low posture bits encode in-plane orientation
// - posture bits ignore the event hold mode
// - posture frozen while orientation blocking active
// - bit 3 gives high-g trigger polarity
// - bits 2..0 name axes firing high-g
// - flags set only by enabled triggering engines
// - hold mode governs non-posture flag holding
// - overflow sticky until queue setup write
// - low seven bits give stored frame count
// - count zeroes on drain or setup write
// - range code selects full scale, legal only
// - bandwidth code selects filter cutoff
// - three power bits select power mode
// - doze code sets low power sleep length
module asp_status_power_regs
  import asp_pkg::*;
#(
  parameter int unsigned TEMP_HOLD_CYCLES = 1000
)
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Detection engines.
  input  wire logic        flat_level_i,
  input  wire logic        flat_en_i,
  input  wire logic [2:0]  orient_i,
  input  wire logic        orient_block_i,
  input  wire logic        high_trig_i,
  input  wire logic        high_en_i,
  input  wire asp_high_t   high_evt_i,
  input  wire asp_hold_t   hold_mode_i,
  input  wire logic        hold_clear_i,
  // Queue events.
  input  wire logic        frame_push_i,
  input  wire logic        frame_pop_i,
  input  wire logic        queue_setup_wr_i,
  // Decoded configuration.
  output asp_fs_t          full_scale_o,
  output logic [4:0]       filter_cutoff_code_o,
  output logic [16:0]      cutoff_chz_o,
  output asp_pmode_t       power_mode_o,
  output logic [19:0]      sleep_us_o
);

  logic [7:0]  range_reg;
  logic [7:0]  cutoff_reg;
  logic [7:0]  power_reg;
  logic [7:0]  posture_q;
  logic [2:0]  orient_q;
  logic        flat_lat;
  logic        high_lat;
  asp_high_t   high_cap;
  logic [23:0] hold_timer;
  logic [6:0]  queue_count;
  logic        queue_ovf;
  logic        access;
  logic        mapped;
  logic        wr_commit;
  logic [5:0]  idx;
  logic [7:0]  rd_byte;
  logic        flat_src;
  logic        high_src;
  logic        release_hold;
  logic        held_mode;
  logic        next_flat;
  asp_high_t   next_high;

  assign access    = psel_i && penable_i;
  assign idx       = paddr_i[7:2];
  assign wr_commit = access && pready_o && pwrite_i && pstrb_i[0] && mapped;

  // Address decode: only aligned words at the five indices answer.
  always_comb
  begin
    mapped = 1'b0;
    if (paddr_i[1:0] != 2'b00)
      mapped = 1'b0;
    else if (idx == IDX_POSTURE)
      mapped = 1'b1;
    else if (idx == IDX_QUEUE)
      mapped = 1'b1;
    else if (idx == IDX_RANGE)
      mapped = 1'b1;
    else if (idx == IDX_CUTOFF)
      mapped = 1'b1;
    else if (idx == IDX_POWER)
      mapped = 1'b1;
  end

  always_comb
  begin
    rd_byte = 8'h00;
    if (idx == IDX_POSTURE)
      rd_byte = posture_q;
    else if (idx == IDX_QUEUE)
      rd_byte = {queue_ovf, queue_count};
    else if (idx == IDX_RANGE)
      rd_byte = range_reg & RANGE_MASK;
    else if (idx == IDX_CUTOFF)
      rd_byte = cutoff_reg & CUTOFF_MASK;
    else if (idx == IDX_POWER)
      rd_byte = power_reg & POWER_MASK;
  end

  // One wait state: the answer comes in the second access cycle, which
  // keeps the read mux off the path from the bus pins to the outputs.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pready_o <= 1'b0;
    else
      pready_o <= access && !pready_o;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (access && !pready_o)
    begin
      prdata_o  <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr_o <= !mapped;
    end
    else
      pslverr_o <= 1'b0;
  end

  // Status registers silently drop writes; reserved bits are not stored.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      range_reg  <= RANGE_RST;
      cutoff_reg <= CUTOFF_RST;
      power_reg  <= POWER_RST;
    end
    else if (wr_commit)
    begin
      if (idx == IDX_RANGE)
        range_reg <= pwdata_i[7:0] & RANGE_MASK;
      else if (idx == IDX_CUTOFF)
        cutoff_reg <= pwdata_i[7:0] & CUTOFF_MASK;
      else if (idx == IDX_POWER)
        power_reg <= pwdata_i[7:0] & POWER_MASK;
    end
  end

  // Reserved range codes leave the previous full scale in force.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      full_scale_o <= ASP_FS_2G;
    else if (range_reg[3:0] == RANGE_2G)
      full_scale_o <= ASP_FS_2G;
    else if (range_reg[3:0] == RANGE_4G)
      full_scale_o <= ASP_FS_4G;
    else if (range_reg[3:0] == RANGE_8G)
      full_scale_o <= ASP_FS_8G;
    else if (range_reg[3:0] == RANGE_16G)
      full_scale_o <= ASP_FS_16G;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      filter_cutoff_code_o <= CUTOFF_RST[4:0];
      cutoff_chz_o         <= 17'(CUT_1000_HZ);
    end
    else
    begin
      filter_cutoff_code_o <= cutoff_reg[4:0];
      cutoff_chz_o         <= asp_cutoff(cutoff_reg[4:0]);
    end
  end

  // Illegal mode combinations are not acted on; the last mode stays.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      power_mode_o <= ASP_PM_NORMAL;
    else
    begin
      case (power_reg[PWR_MODE_LSB +: 3])
        PWR_NORMAL_CD: power_mode_o <= ASP_PM_NORMAL;
        PWR_DEEP_CD:   power_mode_o <= ASP_PM_DEEP;
        PWR_LOW_CD:    power_mode_o <= ASP_PM_LOW;
        PWR_SUSP_CD:   power_mode_o <= ASP_PM_SUSP;
        default:       power_mode_o <= power_mode_o;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sleep_us_o <= 20'(SLP_0_5_MS);
    else
      sleep_us_o <= asp_sleep(power_reg[SLEEP_LSB +: 4]);
  end

  // Posture follows the engine except while blocking is active.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      orient_q <= 3'h0;
    else if (!orient_block_i)
      orient_q <= orient_i;
  end

  assign flat_src  = flat_level_i && flat_en_i;
  assign high_src  = high_trig_i && high_en_i;
  assign held_mode = (hold_mode_i == ASP_HOLD_TEMP) ||
                     (hold_mode_i == ASP_HOLD_PERM);
  assign release_hold = hold_clear_i ||
                        ((hold_mode_i == ASP_HOLD_TEMP) &&
                         (hold_timer == 24'h00_0001));

  // Temporary hold restarts on every new trigger.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      hold_timer <= 24'h00_0000;
    else if (hold_mode_i != ASP_HOLD_TEMP)
      hold_timer <= 24'h00_0000;
    else if (flat_src || high_src)
      hold_timer <= 24'(TEMP_HOLD_CYCLES);
    else if (hold_timer != 24'h00_0000)
      hold_timer <= hold_timer - 24'h00_0001;
  end

  // A trigger in the release cycle wins over the release.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      flat_lat <= 1'b0;
    else if (flat_src && held_mode)
      flat_lat <= 1'b1;
    else if (release_hold || !held_mode)
      flat_lat <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      high_lat <= 1'b0;
      high_cap <= '0;
    end
    else if (high_src && held_mode)
    begin
      high_lat <= 1'b1;
      high_cap <= high_evt_i;
    end
    else if (release_hold || !held_mode)
      high_lat <= 1'b0;
  end

  always_comb
  begin
    next_flat = flat_src || (held_mode && flat_lat);
    next_high = '0;
    if (high_src)
      next_high = high_evt_i;
    else if (held_mode && high_lat)
      next_high = high_cap;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      posture_q <= 8'h00;
    else
    begin
      posture_q[POST_FLAT_BIT]          <= next_flat;
      posture_q[POST_ORIENT_LSB +: 3]   <= orient_q;
      posture_q[3:0]                    <= next_high;
    end
  end

  asp_queue_stat asp_queue_stat_inst (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .frame_push_i (frame_push_i),
    .frame_pop_i  (frame_pop_i),
    .setup_wr_i   (queue_setup_wr_i),
    .count_o      (queue_count),
    .overflow_o   (queue_ovf)
  );

  chk_flat_live: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    hold_mode_i == ASP_HOLD_NONE |=>
      posture_q[POST_FLAT_BIT] == $past(flat_level_i && flat_en_i))
    else $error("flat bit does not follow enabled flat level");

  chk_orient_track: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !orient_block_i ##1 1'b1 |=>
      posture_q[POST_ORIENT_LSB +: 3] == $past(orient_i, 2))
    else $error("posture bits do not follow orientation");

  chk_orient_nohold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    hold_clear_i && !orient_block_i ##1 1'b1 |=>
      posture_q[POST_ORIENT_LSB +: 3] == $past(orient_i, 2))
    else $error("posture bits touched by hold release");

  chk_orient_block: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    orient_block_i ##1 orient_block_i |=>
      $stable(posture_q[POST_ORIENT_LSB +: 3]))
    else $error("posture bits changed while blocked");

  chk_high_capture: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    high_trig_i && high_en_i |=> posture_q[3:0] == $past(high_evt_i))
    else $error("high-g sign or axes not captured");

  chk_disabled_quiet: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    hold_mode_i == ASP_HOLD_NONE && !high_en_i && !flat_en_i |=>
      posture_q[POST_FLAT_BIT] == 1'b0 && posture_q[3:0] == 4'h0)
    else $error("flag set by a disabled engine");

  chk_perm_hold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    flat_src && hold_mode_i == ASP_HOLD_PERM ##1
      (hold_mode_i == ASP_HOLD_PERM && !hold_clear_i) [*3] |=>
      posture_q[POST_FLAT_BIT])
    else $error("permanently held flat flag dropped");

  chk_range_4g: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    range_reg[3:0] == RANGE_4G |=> full_scale_o == ASP_FS_4G)
    else $error("range code did not select four g");

  chk_cutoff_top: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cutoff_reg[4] |=> cutoff_chz_o == 17'(CUT_1000_HZ))
    else $error("high bandwidth code not at top cutoff");

  chk_pmode_low: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    power_reg[PWR_MODE_LSB +: 3] == PWR_LOW_CD |=> power_mode_o == ASP_PM_LOW)
    else $error("power bits did not select low power");

  chk_sleep_min: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    power_reg[SLEEP_LSB +: 4] <= 4'h5 |=> sleep_us_o == 20'(SLP_0_5_MS))
    else $error("short doze codes not at half a millisecond");

  chk_apb_ready: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    access && !pready_o |=> pready_o ##1 !pready_o)
    else $error("APB ready not a single pulse after one wait");

endmodule : asp_status_power_regs

// [test/asp_status_power_regs_bench.sv]
// Self-checking bench for the status and power register slice.
`timescale 1ns/1ps
module asp_status_power_regs_bench;
  import asp_pkg::*;
  localparam logic [7:0] A_POST = {IDX_POSTURE, 2'b00};
  localparam logic [7:0] A_QUE  = {IDX_QUEUE, 2'b00};
  localparam logic [7:0] A_RNG  = {IDX_RANGE, 2'b00};
  localparam logic [7:0] A_CUT  = {IDX_CUTOFF, 2'b00};
  localparam logic [7:0] A_PWR  = {IDX_POWER, 2'b00};
  logic clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdata;
  logic [3:0] pstrb_i = 4'hf;
  logic pready_o, pslverr_o, rerr;
  logic flat_level_i = 0, flat_en_i = 0, orient_block_i = 0, high_trig_i = 0;
  logic high_en_i = 0, hold_clear_i = 0;
  logic frame_push_i = 0, frame_pop_i = 0, queue_setup_wr_i = 0;
  logic [2:0] orient_i = 3'h0;
  asp_high_t high_evt_i = 4'h0;
  asp_hold_t hold_mode_i = ASP_HOLD_NONE;
  asp_fs_t full_scale_o;
  asp_pmode_t power_mode_o;
  logic [4:0] filter_cutoff_code_o;
  logic [16:0] cutoff_chz_o;
  logic [19:0] sleep_us_o;
  int failures = 0, total_checks = 0;
  asp_status_power_regs #(.TEMP_HOLD_CYCLES(8)) asp_status_power_regs_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .flat_level_i(flat_level_i), .flat_en_i(flat_en_i),
    .orient_i(orient_i), .orient_block_i(orient_block_i),
    .high_trig_i(high_trig_i), .high_en_i(high_en_i),
    .high_evt_i(high_evt_i), .hold_mode_i(hold_mode_i),
    .hold_clear_i(hold_clear_i), .frame_push_i(frame_push_i),
    .frame_pop_i(frame_pop_i), .queue_setup_wr_i(queue_setup_wr_i),
    .full_scale_o(full_scale_o), .filter_cutoff_code_o(filter_cutoff_code_o),
    .cutoff_chz_o(cutoff_chz_o), .power_mode_o(power_mode_o),
    .sleep_us_o(sleep_us_o));
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s saw %h wanted %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // Pready is read before the edge's own updates land, so it is the value
  // sampled at that edge; read data is taken at the same edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= wr; paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 0; penable_i <= 0;
  endtask : apb
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask : settle
  task automatic t_reset;
    apb(0, A_RNG, 0); chk(rdata, 32'h03, "range rst");
    apb(0, A_CUT, 0); chk(rdata, 32'h0f, "cut rst");
    apb(0, A_PWR, 0); chk(rdata, 32'h00, "pwr rst");
    chk(cutoff_chz_o, CUT_1000_HZ, "cut rst out");
    chk(sleep_us_o, SLP_0_5_MS, "sleep rst out");
    chk(full_scale_o, ASP_FS_2G, "fs rst out");
    chk(power_mode_o, ASP_PM_NORMAL, "pm rst out");
    chk(filter_cutoff_code_o, CUTOFF_RST[4:0], "code rst out");
    $display("reset values done");
  endtask : t_reset
  task automatic t_range;
    logic [3:0] rc [4] = '{RANGE_2G, RANGE_4G, RANGE_8G, RANGE_16G};
    asp_fs_t fe [4] = '{ASP_FS_2G, ASP_FS_4G, ASP_FS_8G, ASP_FS_16G};
    for (int i = 0; i < 4; i++)
    begin
      apb(1, A_RNG, {4'h0, rc[i]}); settle();
      chk(full_scale_o, fe[i], "full scale");
      apb(0, A_RNG, 0); chk(rdata, rc[i], "range rb");
    end
    // An unlisted code is stored but must not move the decoded range.
    apb(1, A_RNG, 8'h07); settle();
    chk(full_scale_o, ASP_FS_16G, "illegal range");
    $display("range done");
  endtask : t_range
  task automatic t_cutoff;
    logic [4:0] cc [10] = '{5'h00, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c,
                            5'h0d, 5'h0e, 5'h0f, 5'h17};
    int ce [10] = '{CUT_7_81_HZ, CUT_7_81_HZ, CUT_15_63_HZ, CUT_31_25_HZ,
                    CUT_62_5_HZ, CUT_125_HZ, CUT_250_HZ, CUT_500_HZ,
                    CUT_1000_HZ, CUT_1000_HZ};
    for (int i = 0; i < 10; i++)
    begin
      apb(1, A_CUT, {3'h0, cc[i]}); settle();
      chk(cutoff_chz_o, ce[i], "cutoff");
      chk(filter_cutoff_code_o, cc[i], "cut code");
    end
    apb(1, A_CUT, 8'hff); apb(0, A_CUT, 0);
    chk(rdata, 32'h1f, "cut reserved");
    $display("cutoff done");
  endtask : t_cutoff
  task automatic t_power;
    logic [7:0] pd [6] = '{8'h4d, 8'h0a, 8'h9e, 8'h00, 8'h60, 8'h20};
    asp_pmode_t pm [6] = '{ASP_PM_LOW, ASP_PM_NORMAL, ASP_PM_SUSP,
                           ASP_PM_NORMAL, ASP_PM_NORMAL, ASP_PM_DEEP};
    int ps [6] = '{SLP_1_MS, SLP_0_5_MS, SLP_1_S, SLP_0_5_MS, SLP_0_5_MS,
                   SLP_0_5_MS};
    for (int i = 0; i < 6; i++)
    begin
      apb(1, A_PWR, pd[i]); settle();
      chk(power_mode_o, pm[i], "power mode");
      chk(sleep_us_o, ps[i], "sleep");
      apb(0, A_PWR, 0); chk(rdata, pd[i] & 8'hfe, "pwr rb");
    end
    // Leaving deep suspend keeps the settings; the cutoff is written and read back again.
    apb(1, A_PWR, 8'h00); settle();
    chk(power_mode_o, ASP_PM_NORMAL, "wake");
    apb(1, A_CUT, 8'h1f); apb(0, A_CUT, 0);
    chk(rdata, 32'h1f, "restored");
    $display("power done");
  endtask : t_power
  task automatic t_error;
    apb(0, 8'h34, 0); chk(rdata, 32'h0000_0000, "unmapped");
    chk(rerr, 1, "unmapped err");
    apb(1, 8'h3d, 8'h05); chk(rerr, 1, "unaligned err");
    apb(0, A_RNG, 0); chk(rdata, 32'h07, "dropped write");
    apb(1, A_POST, 8'hff); chk(rerr, 0, "ro write");
    apb(0, A_POST, 0); chk(rdata, 32'h00, "ro kept");
    $display("error access done");
  endtask : t_error
  task automatic t_status;
    orient_i <= 3'h5; flat_level_i <= 1; settle();
    apb(0, A_POST, 0); chk(rdata, 32'h50, "flat disabled");
    flat_en_i <= 1; high_en_i <= 1; high_trig_i <= 1; high_evt_i <= 4'hd;
    hold_mode_i <= ASP_HOLD_PERM; settle();
    apb(0, A_POST, 0); chk(rdata, 32'hdd, "flat high");
    orient_block_i <= 1; settle();
    orient_i <= 3'h2; high_trig_i <= 0; flat_level_i <= 0; settle();
    apb(0, A_POST, 0); chk(rdata, 32'hdd, "blocked held");
    orient_block_i <= 0; settle();
    apb(0, A_POST, 0); chk(rdata, 32'had, "orient new");
    hold_clear_i <= 1; @(posedge clk_i); hold_clear_i <= 0;
    hold_mode_i <= ASP_HOLD_NONE; settle();
    apb(0, A_POST, 0); chk(rdata, 32'h20, "released");
    // One flat trigger in temporary mode stays visible for nine cycles.
    hold_mode_i <= ASP_HOLD_TEMP; flat_level_i <= 1; @(posedge clk_i);
    flat_level_i <= 0; settle();
    apb(0, A_POST, 0); chk(rdata, 32'ha0, "temp held");
    settle();
    apb(0, A_POST, 0); chk(rdata, 32'h20, "temp expired");
    $display("status done");
  endtask : t_status
  task automatic t_queue;
    frame_push_i <= 1;
    repeat (33) @(posedge clk_i);
    frame_push_i <= 0; settle();
    apb(0, A_QUE, 0); chk(rdata, 32'ha0, "full overrun");
    frame_pop_i <= 1; @(posedge clk_i); frame_pop_i <= 0; settle();
    apb(0, A_QUE, 0); chk(rdata, 32'h9f, "ovf sticky");
    queue_setup_wr_i <= 1; @(posedge clk_i); queue_setup_wr_i <= 0; settle();
    apb(0, A_QUE, 0); chk(rdata, 32'h00, "setup clear");
    frame_push_i <= 1; repeat (2) @(posedge clk_i); frame_push_i <= 0; settle();
    apb(0, A_QUE, 0); chk(rdata, 32'h02, "two frames");
    frame_pop_i <= 1; repeat (2) @(posedge clk_i); frame_pop_i <= 0; settle();
    apb(0, A_QUE, 0); chk(rdata, 32'h00, "drained");
    $display("queue done");
  endtask : t_queue
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1;
    t_reset(); t_range(); t_cutoff(); t_power(); t_error();
    t_status(); t_queue();
    wrap_up();
  end
endmodule : asp_status_power_regs_bench
